// file: common/sarc_pkg.sv
// shared constants and types for the i2c sar converter control
package sarc_pkg;

	localparam int RES_BITS     = 12;
	localparam int PAD_BITS     = 4;
	localparam int FRAME_BITS   = RES_BITS + PAD_BITS;
	localparam int CFG_BITS     = 6;
	localparam int ADDR_BITS    = 7;
	localparam int RD_BYTES_MAX = 2;

	localparam logic [3:0] BIT_ZERO  = 4'h0;
	localparam logic [3:0] BIT_LAST  = 4'h7;
	localparam logic [3:0] BYTE_DONE = 4'h8;
	localparam logic [3:0] CFG_LAST  = 4'h5;
	localparam logic [1:0] RD_FIRST  = 2'h0;
	localparam logic [1:0] RD_LIMIT  = 2'h2;

	localparam logic [PAD_BITS-1:0] PAD_ZERO  = 4'h0;
	localparam logic [RES_BITS-1:0] RES_ZERO  = 12'h000;
	localparam logic [RES_BITS-1:0] RES_TOP   = 12'h800;
	localparam logic [3:0]          MSB_INDEX = 4'hB;

	// arbitrary default slave address
	localparam logic [ADDR_BITS-1:0] DEV_ADDR_DEFAULT = 7'h2A;

	// acquisition time and conversion clock period, both in ns
	localparam int ACQ_NS             = 240;
	localparam int CONV_CLK_PERIOD_NS = 30;
	localparam int ACQ_CYC = (ACQ_NS + CONV_CLK_PERIOD_NS - 1) / CONV_CLK_PERIOD_NS;
	localparam int CNT_BITS = 8;

	typedef struct packed {
		logic sgl_diff;
		logic odd_sign;
		logic chan_pick_high;
		logic chan_pick_low;
		logic polarity_mode_bit;
		logic sleep_select_bit;
	} sarc_cfg_s;

	localparam sarc_cfg_s CFG_RESET = 6'h00;

	typedef struct packed {
		logic [2:0] pos;
		logic [2:0] neg;
		logic       neg_shared;
	} sarc_mux_s;

	localparam sarc_mux_s MUX_RESET = 7'h00;

	typedef enum logic [7:0] {
		BUS_IDLE    = 8'h01,
		BUS_ADDR    = 8'h02,
		BUS_ADDR_AK = 8'h04,
		BUS_WR_DATA = 8'h08,
		BUS_WR_AK   = 8'h10,
		BUS_RD_DATA = 8'h20,
		BUS_RD_AK   = 8'h40,
		BUS_IGNORE  = 8'h80
	} sarc_bus_state_e;

	typedef enum logic [2:0] {
		SAR_IDLE   = 3'h1,
		SAR_SAMPLE = 3'h2,
		SAR_DECIDE = 3'h4
	} sarc_sar_state_e;

endpackage

// file: hdl/sarc_sync.sv
// three-stage synchroniser with agreement filter
module sarc_sync
	import sarc_pkg::*;
#(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic d,
	output logic      q
);

	logic ff1_q;
	logic ff2_q;
	logic ff3_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ff1_q <= RESET_VAL;
			ff2_q <= RESET_VAL;
			ff3_q <= RESET_VAL;
		end else begin
			ff1_q <= d;
			ff2_q <= ff1_q;
			ff3_q <= ff2_q;
		end
	end

	// a change counts only once the last two stages agree
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= RESET_VAL;
		end else if (ff2_q == ff3_q) begin
			q <= ff3_q;
		end
	end

endmodule

// file: hdl/sarc_sar_seq.sv
// successive-approximation sequencer on the conversion clock
module sarc_sar_seq
	import sarc_pkg::*;
#(
	parameter int ACQ_CYCLES = ACQ_CYC
) (
	input  wire logic                conv_clk,
	input  wire logic                reset_n,
	input  wire logic                start_tgl,
	input  wire logic                comp_above,
	output logic [RES_BITS-1:0]      dac_code,
	output logic                     sample_hold,
	output logic [RES_BITS-1:0]      result,
	output logic                     done_tgl
);

	sarc_sar_state_e       state_q;
	logic [CNT_BITS-1:0]   cnt_q;
	logic [3:0]            idx_q;
	logic                  start_s;
	logic                  start_p_q;
	logic [RES_BITS-1:0]   kept;

	sarc_sync #(.RESET_VAL(1'b0)) u_start_sync (
		.clk     (conv_clk),
		.reset_n (reset_n),
		.d       (start_tgl),
		.q       (start_s)
	);

	always_ff @(posedge conv_clk or negedge reset_n) begin
		if (!reset_n) begin
			start_p_q <= 1'b0;
		end else begin
			start_p_q <= start_s;
		end
	end

	// trial bit stays only while the input is above the dac
	assign kept = comp_above ? dac_code : (dac_code & ~(RES_TOP >> (MSB_INDEX - idx_q)));

	always_ff @(posedge conv_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q     <= SAR_IDLE;
			cnt_q       <= '0;
			idx_q       <= MSB_INDEX;
			dac_code    <= RES_ZERO;
			sample_hold <= 1'b0;
			result      <= RES_ZERO;
			done_tgl    <= 1'b0;
		end else begin
			case (state_q)
				SAR_IDLE: begin
					if (start_s != start_p_q) begin
						state_q     <= SAR_SAMPLE;
						cnt_q       <= '0;
						sample_hold <= 1'b1;
					end
				end
				SAR_SAMPLE: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == CNT_BITS'(ACQ_CYCLES - 1)) begin
						// both inputs held by one switch
						sample_hold <= 1'b0;
						idx_q       <= MSB_INDEX;
						dac_code    <= RES_TOP;
						state_q     <= SAR_DECIDE;
					end
				end
				SAR_DECIDE: begin
					if (idx_q == BIT_ZERO) begin
						result   <= kept;
						dac_code <= kept;
						done_tgl <= ~done_tgl;
						state_q  <= SAR_IDLE;
					end else begin
						dac_code <= kept | (RES_TOP >> (MSB_INDEX - idx_q + 1'b1));
						idx_q    <= idx_q - 1'b1;
					end
				end
				default: begin
					state_q <= SAR_IDLE;
				end
			endcase
		end
	end

endmodule

// file: hdl/sarc_top.sv
// i2c slave control of the eight-input 12-bit sar converter
// What this block does
// - stop after successful addressing starts conversion
// - requests during conversion are not acknowledged
// - after conversion, addressed requests are acknowledged
// - read returns latest result, no latency
// - twelve result bits msb first, four zeros
// - data changes after scl falling edge
// - write loads six-bit configuration word
// - config bits captured on rising edges, ordered
// - sar decides bits msb down to lsb
// - sar result moves to output latches
// - mux decoded from four configuration bits
// - differential pairs, odd bit swaps polarity
// - single-ended channel is twice select plus odd
// - positive and negative inputs sampled together
// - each conversion uses latest configuration
// - polarity bit and sleep bit select modes
// - bipolar twos complement, unipolar straight binary
// - nap or sleep after each conversion
// - last two written bits are ignored
module sarc_top
	import sarc_pkg::*;
#(
	parameter logic [ADDR_BITS-1:0] DEV_ADDR   = DEV_ADDR_DEFAULT,
	parameter int                   ACQ_CYCLES = ACQ_CYC
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              conv_clk,
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe_n,
	input  wire logic              comp_above,
	output logic [RES_BITS-1:0]    dac_code,
	output logic                   sample_hold,
	output sarc_mux_s              mux_sel,
	output logic                   bipolar_mode,
	output logic                   nap_mode,
	output logic                   sleep_mode,
	output logic                   conv_busy
);

	// decodes a configuration word into the multiplexer setting
	function automatic sarc_mux_s mux_decode(input sarc_cfg_s c);
		sarc_mux_s m;
		m.pos        = {c.chan_pick_high, c.chan_pick_low, c.odd_sign};
		m.neg        = {c.chan_pick_high, c.chan_pick_low, ~c.odd_sign};
		m.neg_shared = c.sgl_diff;
		return m;
	endfunction

	logic                   scl_f;
	logic                   sda_f;
	logic                   scl_p_q;
	logic                   sda_p_q;
	logic                   scl_rise;
	logic                   scl_fall;
	logic                   start_c;
	logic                   stop_c;

	sarc_bus_state_e        state_q;
	logic [3:0]             bit_q;
	logic [7:0]             shift_q;
	logic                   rw_q;
	logic [1:0]             byte_q;
	logic                   mack_q;
	logic [FRAME_BITS-1:0]  tx_q;
	logic                   addressed_q;
	logic [CFG_BITS-2:0]    cfg_shift_q;
	sarc_cfg_s              cfg_q;
	logic                   busy_q;
	logic [RES_BITS-1:0]    result_q;
	logic                   start_tgl_q;
	logic                   done_s;
	logic                   done_p_q;
	logic                   done_evt;
	logic [RES_BITS-1:0]    sar_result;
	logic                   sar_done_tgl;
	logic [FRAME_BITS-1:0]  frame;
	logic                   addr_ok;

	// bus pins arrive unsynchronised
	sarc_sync #(.RESET_VAL(1'b1)) u_scl_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (scl_i),
		.q       (scl_f)
	);

	sarc_sync #(.RESET_VAL(1'b1)) u_sda_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (sda_i),
		.q       (sda_f)
	);

	sarc_sync #(.RESET_VAL(1'b0)) u_done_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (sar_done_tgl),
		.q       (done_s)
	);

	sarc_sar_seq #(.ACQ_CYCLES(ACQ_CYCLES)) u_sar (
		.conv_clk    (conv_clk),
		.reset_n     (reset_n),
		.start_tgl   (start_tgl_q),
		.comp_above  (comp_above),
		.dac_code    (dac_code),
		.sample_hold (sample_hold),
		.result      (sar_result),
		.done_tgl    (sar_done_tgl)
	);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_p_q  <= 1'b1;
			sda_p_q  <= 1'b1;
			done_p_q <= 1'b0;
		end else begin
			scl_p_q  <= scl_f;
			sda_p_q  <= sda_f;
			done_p_q <= done_s;
		end
	end

	// edges and bus conditions seen on the filtered levels
	assign scl_rise = scl_f & ~scl_p_q;
	assign scl_fall = ~scl_f & scl_p_q;
	assign start_c  = scl_f & scl_p_q & sda_p_q & ~sda_f;
	assign stop_c   = scl_f & scl_p_q & ~sda_p_q & sda_f;
	assign done_evt = done_s ^ done_p_q;

	// result latched when the last conversion ended, so reads need no wait
	assign frame   = {result_q, PAD_ZERO};
	assign addr_ok = (shift_q[7:1] == DEV_ADDR) && !busy_q;

	// open drain: the line is only ever pulled low
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
		end
	end

	// byte engine; every sda change waits for a falling scl
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q  <= BUS_IDLE;
			bit_q    <= BIT_ZERO;
			shift_q  <= '0;
			rw_q     <= 1'b0;
			byte_q   <= RD_FIRST;
			mack_q   <= 1'b0;
			tx_q     <= '0;
			sda_oe_n <= 1'b1;
		end else if (start_c) begin
			// repeated start restarts the address phase
			state_q  <= BUS_ADDR;
			bit_q    <= BIT_ZERO;
			sda_oe_n <= 1'b1;
		end else if (stop_c) begin
			state_q  <= BUS_IDLE;
			sda_oe_n <= 1'b1;
		end else begin
			case (state_q)
				BUS_IDLE: begin
					sda_oe_n <= 1'b1;
				end
				BUS_ADDR: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_f};
						bit_q   <= bit_q + 1'b1;
					end else if (scl_fall && bit_q == BYTE_DONE) begin
						bit_q <= BIT_ZERO;
						rw_q  <= shift_q[0];
						if (addr_ok) begin
							sda_oe_n <= 1'b0;
							state_q  <= BUS_ADDR_AK;
						end else begin
							// busy leaves the line released: a nack
							state_q <= BUS_IGNORE;
						end
					end
				end
				BUS_ADDR_AK: begin
					if (scl_fall) begin
						byte_q <= RD_FIRST;
						if (rw_q) begin
							sda_oe_n <= frame[FRAME_BITS-1];
							tx_q     <= frame << 1;
							state_q  <= BUS_RD_DATA;
						end else begin
							sda_oe_n <= 1'b1;
							state_q  <= BUS_WR_DATA;
						end
					end
				end
				BUS_WR_DATA: begin
					if (scl_rise) begin
						bit_q <= bit_q + 1'b1;
					end else if (scl_fall && bit_q == BYTE_DONE) begin
						bit_q    <= BIT_ZERO;
						sda_oe_n <= 1'b0;
						state_q  <= BUS_WR_AK;
					end
				end
				BUS_WR_AK: begin
					// one byte per write, further bytes are not taken
					if (scl_fall) begin
						sda_oe_n <= 1'b1;
						state_q  <= BUS_IGNORE;
					end
				end
				BUS_RD_DATA: begin
					if (scl_fall) begin
						if (bit_q == BIT_LAST) begin
							bit_q    <= BIT_ZERO;
							sda_oe_n <= 1'b1;
							state_q  <= BUS_RD_AK;
						end else begin
							bit_q    <= bit_q + 1'b1;
							sda_oe_n <= tx_q[FRAME_BITS-1];
							tx_q     <= tx_q << 1;
						end
					end
				end
				BUS_RD_AK: begin
					if (scl_rise) begin
						mack_q <= ~sda_f;
					end else if (scl_fall) begin
						byte_q <= byte_q + 1'b1;
						// the frame ends after two bytes
						if (mack_q && (byte_q + 1'b1) < RD_LIMIT) begin
							sda_oe_n <= tx_q[FRAME_BITS-1];
							tx_q     <= tx_q << 1;
							state_q  <= BUS_RD_DATA;
						end else begin
							state_q <= BUS_IGNORE;
						end
					end
				end
				BUS_IGNORE: begin
					sda_oe_n <= 1'b1;
				end
				default: begin
					state_q  <= BUS_IDLE;
					sda_oe_n <= 1'b1;
				end
			endcase
		end
	end

	// configuration word taken bit by bit, the two trailing bits dropped
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_shift_q <= '0;
			cfg_q       <= CFG_RESET;
		end else if (state_q == BUS_WR_DATA && scl_rise) begin
			if (bit_q < CFG_LAST) begin
				cfg_shift_q <= {cfg_shift_q[CFG_BITS-3:0], sda_f};
			end else if (bit_q == CFG_LAST) begin
				cfg_q <= {cfg_shift_q, sda_f};
			end
		end
	end

	// remembers a successful address until the frame ends
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addressed_q <= 1'b0;
		end else if (stop_c) begin
			addressed_q <= 1'b0;
		end else if (state_q == BUS_ADDR && scl_fall && bit_q == BYTE_DONE && addr_ok) begin
			addressed_q <= 1'b1;
		end
	end

	// conversion launch and completion; launch wins, a stop while busy starts nothing
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			start_tgl_q <= 1'b0;
			busy_q      <= 1'b0;
		end else if (stop_c && addressed_q && !busy_q) begin
			start_tgl_q <= ~start_tgl_q;
			busy_q      <= 1'b1;
		end else if (done_evt) begin
			busy_q <= 1'b0;
		end
	end

	// settings frozen for the conversion being started
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mux_sel      <= MUX_RESET;
			bipolar_mode <= 1'b0;
		end else if (stop_c && addressed_q && !busy_q) begin
			mux_sel      <= mux_decode(cfg_q);
			bipolar_mode <= ~cfg_q.polarity_mode_bit;
		end
	end

	// sar data is stable once its done toggle is seen here
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			result_q <= RES_ZERO;
		end else if (done_evt) begin
			if (bipolar_mode) begin
				result_q <= {~sar_result[RES_BITS-1], sar_result[RES_BITS-2:0]};
			end else begin
				result_q <= sar_result;
			end
		end
	end

	// low power state between conversions
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			nap_mode   <= 1'b0;
			sleep_mode <= 1'b0;
		end else if (stop_c && addressed_q && !busy_q) begin
			nap_mode   <= 1'b0;
			sleep_mode <= 1'b0;
		end else if (done_evt) begin
			nap_mode   <= ~cfg_q.sleep_select_bit;
			sleep_mode <= cfg_q.sleep_select_bit;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			conv_busy <= 1'b0;
		end else begin
			conv_busy <= busy_q;
		end
	end

endmodule

// file: verif/sarc_top_sva.sv
// port checks for the converter control
module sarc_top_chk
	import sarc_pkg::*;
(
	input wire logic                clk,
	input wire logic                reset_n,
	input wire logic                conv_clk,
	input wire logic                scl_i,
	input wire logic                sda_oe_n,
	input wire logic [RES_BITS-1:0] dac_code,
	input wire logic                sample_hold,
	input wire sarc_mux_s           mux_sel,
	input wire logic                bipolar_mode,
	input wire logic                nap_mode,
	input wire logic                sleep_mode,
	input wire logic                conv_busy
);
	// filter delay is under the 8 clk scl low time, so drive moves while scl is low
	chk_out_fall: assert property (@(posedge clk) disable iff (!reset_n)
		$changed(sda_oe_n) |-> !scl_i)
		else $error("sda drive moved while scl high");
	chk_busy_quiet: assert property (@(posedge clk) disable iff (!reset_n)
		conv_busy |-> sda_oe_n)
		else $error("sda driven during conversion");
	chk_mux_hold: assert property (@(posedge clk) disable iff (!reset_n)
		conv_busy && $past(conv_busy) |-> $stable(mux_sel) && $stable(bipolar_mode))
		else $error("mode changed during conversion");
	chk_busy_min: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(conv_busy) |-> conv_busy[*8])
		else $error("conversion ended too early");
	chk_busy_end: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(conv_busy) |-> ##[1:1000] !conv_busy)
		else $error("conversion never ended");
	chk_idle_mode: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(conv_busy) |-> ##[0:2] (nap_mode != sleep_mode))
		else $error("no idle mode after conversion");
	chk_mode_excl: assert property (@(posedge clk) disable iff (!reset_n)
		!(nap_mode && sleep_mode))
		else $error("nap and sleep both set");
	chk_sar_msb: assert property (@(posedge conv_clk) disable iff (!reset_n)
		$fell(sample_hold) |-> ##[0:1] (dac_code == RES_TOP))
		else $error("first trial is not the msb");
endmodule

bind sarc_top sarc_top_chk chk_u (
	.clk         (clk),
	.reset_n     (reset_n),
	.conv_clk    (conv_clk),
	.scl_i       (scl_i),
	.sda_oe_n    (sda_oe_n),
	.dac_code    (dac_code),
	.sample_hold (sample_hold),
	.mux_sel     (mux_sel),
	.bipolar_mode(bipolar_mode),
	.nap_mode    (nap_mode),
	.sleep_mode  (sleep_mode),
	.conv_busy   (conv_busy)
);

// file: verif/sarc_i2c_master.sv
// i2c master model for the converter port
module sarc_i2c_master (
	input  wire logic clk,
	input  wire logic sda_w,
	output logic      scl,
	output logic      sda_rel
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	task automatic half();
		repeat (8) @(negedge clk);
	endtask
	// sda moves 2 clk into scl low so the slave filter never sees a false stop
	task automatic start();
		repeat (2) @(negedge clk);
		sda_rel = 1'b1;
		repeat (6) @(negedge clk);
		scl = 1'b1;
		half();
		sda_rel = 1'b0;
		half();
		scl = 1'b0;
	endtask
	task automatic stop();
		repeat (2) @(negedge clk);
		sda_rel = 1'b0;
		repeat (6) @(negedge clk);
		scl = 1'b1;
		half();
		sda_rel = 1'b1;
		half();
	endtask
	task automatic bit_io(input logic b, output logic r);
		repeat (2) @(negedge clk);
		sda_rel = b;
		repeat (6) @(negedge clk);
		scl = 1'b1;
		r = sda_w;
		half();
		scl = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] tx, input logic ak_in,
		output logic [7:0] rx, output logic ak);
		for (int k = 7; k >= 0; k--) begin
			bit_io(tx[k], rx[k]);
		end
		bit_io(ak_in, ak);
	endtask
endmodule

// file: verif/test_sarc_top.sv
// self-checking bench for the converter control
module test_sarc_top
	import sarc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                clk = 1'b0;
	logic                conv_clk = 1'b0;
	logic                reset_n = 1'b0;
	logic                scl;
	logic                sda_rel;
	logic                sda_o;
	logic                sda_oe_n;
	logic [RES_BITS-1:0] dac_code;
	logic [RES_BITS-1:0] vin = 12'h000;
	logic                sample_hold;
	sarc_mux_s           mux_sel;
	logic                bipolar_mode;
	logic                nap_mode;
	logic                sleep_mode;
	logic                conv_busy;
	int                  fails = 0;
	int                  n_tests = 0;
	// pull-up on sda; half an lsb added so the comparator never sees a tie
	wire sda_w = sda_rel & (sda_oe_n | sda_o);
	wire comp_above = {vin, 1'b1} > {dac_code, 1'b0};
	always #20 clk = ~clk;
	always #15 conv_clk = ~conv_clk;
	sarc_top #(
		.ACQ_CYCLES(250)
	) dut_u (
		.clk         (clk),
		.reset_n     (reset_n),
		.conv_clk    (conv_clk),
		.scl_i       (scl),
		.sda_i       (sda_w),
		.sda_o       (sda_o),
		.sda_oe_n    (sda_oe_n),
		.comp_above  (comp_above),
		.dac_code    (dac_code),
		.sample_hold (sample_hold),
		.mux_sel     (mux_sel),
		.bipolar_mode(bipolar_mode),
		.nap_mode    (nap_mode),
		.sleep_mode  (sleep_mode),
		.conv_busy   (conv_busy)
	);
	sarc_i2c_master m_u (
		.clk    (clk),
		.sda_w  (sda_w),
		.scl    (scl),
		.sda_rel(sda_rel)
	);
	task automatic eq_bit(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic eq_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#3000000;
		fails++;
		$display("[ERR] watchdog exp done got hang");
		tally_and_finish();
	end
	initial begin
		logic [7:0]  b0;
		logic [7:0]  b1;
		logic        ak;
		logic [3:0]  c;
		logic        unipolar;
		logic        sleep_sel;
		logic [11:0] v;
		repeat (8) @(negedge clk);
		eq_bit("oe_rst", 1'b1, sda_oe_n);
		eq_bit("busy_rst", 1'b0, conv_busy);
		reset_n = 1'b1;
		repeat (6) @(negedge clk);
		m_u.start();
		m_u.xfer({DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, 1'b1, b0, ak);
		eq_bit("ack_foreign", 1'b1, ak);
		m_u.stop();
		eq_bit("busy_foreign", 1'b0, conv_busy);
		// every mux code once; polarity, sleep and ignored bits vary with it
		for (int i = 0; i < 16; i++) begin
			c = i[3:0];
			unipolar = c[0] ^ c[2];
			sleep_sel = c[1] ^ c[3];
			v = {c, 8'h5A};
			vin = v;
			m_u.start();
			m_u.xfer({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, b0, ak);
			eq_bit("ack_wr", 1'b0, ak);
			m_u.xfer({c, unipolar, sleep_sel, ~c[1:0]}, 1'b1, b0, ak);
			eq_bit("ack_cfg", 1'b0, ak);
			m_u.stop();
			eq_bit("busy", 1'b1, conv_busy);
			eq_word("mux_pos", {13'h0, c[1:0], c[2]}, {13'h0, mux_sel.pos});
			eq_bit("mux_shared", c[3], mux_sel.neg_shared);
			if (!c[3]) begin
				eq_word("mux_neg", {13'h0, c[1:0], ~c[2]}, {13'h0, mux_sel.neg});
			end
			eq_bit("bipolar", ~unipolar, bipolar_mode);
			m_u.start();
			m_u.xfer({DEV_ADDR_DEFAULT, 1'b1}, 1'b1, b0, ak);
			eq_bit("ack_busy", 1'b1, ak);
			m_u.stop();
			for (int w = 0; w < 1000 && conv_busy !== 1'b0; w++) begin
				@(negedge clk);
			end
			repeat (4) @(negedge clk);
			eq_bit("busy_end", 1'b0, conv_busy);
			eq_bit("nap", ~sleep_sel, nap_mode);
			eq_bit("sleep", sleep_sel, sleep_mode);
			m_u.start();
			m_u.xfer({DEV_ADDR_DEFAULT, 1'b1}, 1'b1, b0, ak);
			eq_bit("ack_rd", 1'b0, ak);
			m_u.xfer(8'hFF, 1'b0, b0, ak);
			m_u.xfer(8'hFF, 1'b1, b1, ak);
			eq_word("result", {v ^ (unipolar ? RES_ZERO : RES_TOP), PAD_ZERO}, {b0, b1});
		end
		m_u.stop();
		tally_and_finish();
	end
endmodule
